/* File: pdt_pkg.sv */
`default_nettype none
package pdt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PDT_DATA_W = 32;
  localparam int PDT_ADDR_W = 8;
  localparam int PDT_CNT_W  = 24;
  localparam int PDT_PRE_W  = 5;
  localparam int PDT_SYNC_W = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [PDT_ADDR_W-1:0] PDT_OFS_CTRL    = 8'h00;
  localparam logic [PDT_ADDR_W-1:0] PDT_OFS_STATUS  = 8'h04;
  localparam logic [PDT_ADDR_W-1:0] PDT_OFS_PRELOAD = 8'h08;
  localparam logic [PDT_ADDR_W-1:0] PDT_OFS_COUNT   = 8'h0C;
  localparam logic [PDT_ADDR_W-1:0] PDT_OFS_VECTOR  = 8'h10;
  localparam logic [PDT_ADDR_W-1:0] PDT_OFS_PORTC   = 8'h14;

  // ----------------------------------------------------------------
  // Reset values and counter constants
  // ----------------------------------------------------------------
  localparam logic [7:0]           PDT_CTRL_RST   = 8'h00;
  localparam logic [7:0]           PDT_VECTOR_RST = 8'h0F;
  localparam logic [7:0]           PDT_PORTC_RST  = 8'h00;
  localparam logic [PDT_CNT_W-1:0] PDT_CNT_ZERO   = 24'h000000;
  localparam logic [PDT_CNT_W-1:0] PDT_CNT_ONE    = 24'h000001;
  localparam logic [PDT_PRE_W-1:0] PDT_PRE_TOP    = 5'h1F;
  localparam logic [PDT_PRE_W-1:0] PDT_PRE_ZERO   = 5'h00;
  localparam logic [PDT_PRE_W-1:0] PDT_PRE_ONE    = 5'h01;

  // ----------------------------------------------------------------
  // Pin modes (control bits 7-5) and clock selects (bits 2-1)
  // ----------------------------------------------------------------
  localparam logic [1:0] PDT_PIN_PORT        = 2'h0;
  localparam logic [1:0] PDT_PIN_SQUARE      = 2'h1;
  localparam logic [2:0] PDT_PIN_IRQ_OFF_VEC = 3'h4;
  localparam logic [2:0] PDT_PIN_IRQ_VEC     = 3'h5;
  localparam logic [2:0] PDT_PIN_IRQ_OFF_AUT = 3'h6;
  localparam logic [2:0] PDT_PIN_IRQ_AUTO    = 3'h7;

  localparam logic [1:0] PDT_CS_SYS     = 2'h0;
  localparam logic [1:0] PDT_CS_GATE    = 2'h1;
  localparam logic [1:0] PDT_CS_EXT_PRE = 2'h2;
  localparam logic [1:0] PDT_CS_EXT     = 2'h3;

  // ----------------------------------------------------------------
  // Synchroniser lanes and port C register fields
  // ----------------------------------------------------------------
  localparam int               PDT_SYNC_TIN = 0;
  localparam int               PDT_SYNC_ACK = 1;
  localparam int               PDT_SYNC_C3  = 2;
  localparam logic [2:0]       PDT_SYNC_RST = 3'h2;
  localparam int               PDT_PC_C2    = 0;
  localparam int               PDT_PC_C3    = 1;
  localparam int               PDT_PC_C7    = 2;
  localparam int               PDT_PC_DIR   = 4;
  localparam int               PDT_PC_PIN   = 8;
  localparam int               PDT_ST_FLAG  = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] pin_mode;
    logic       rollover;
    logic       unused;
    logic [1:0] clk_sel;
    logic       enable;
  } pdt_ctrl_type;

  typedef struct packed {
    logic o;
    logic oe;
  } pdt_drive_type;

endpackage : pdt_pkg
`default_nettype wire

/* File: pdt_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pdt_sync
  import pdt_pkg::*;
#(
  parameter int                     WIDTH   = PDT_SYNC_W,
  parameter logic [PDT_SYNC_W-1:0]  RST_VAL = PDT_SYNC_RST
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  // ----------------------------------------------------------------
  // Two flop synchroniser per lane
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_lane
      logic meta_reg;
      logic meta_next;
      logic sync_next;

      always_comb begin
        meta_next = d_i[gi];
        sync_next = meta_reg;
      end

      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          meta_reg  <= RST_VAL[gi];
          q_o[gi]   <= RST_VAL[gi];
        end else begin
          meta_reg  <= meta_next;
          q_o[gi]   <= sync_next;
        end
      end
    end
  endgenerate

endmodule : pdt_sync
`default_nettype wire

/* File: pdt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module pdt_prescaler
  import pdt_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic step_i,
  output var  logic wrap_o
);

  // ----------------------------------------------------------------
  // Five bit down counter, wraps 00 to 1F
  // ----------------------------------------------------------------
  logic [PDT_PRE_W-1:0] pre_reg;
  logic [PDT_PRE_W-1:0] pre_next;

  always_comb begin
    pre_next = pre_reg;
    wrap_o   = 1'b0;
    if (step_i) begin
      if (pre_reg == PDT_PRE_ZERO) begin
        pre_next = PDT_PRE_TOP;
        wrap_o   = 1'b1;
      end else begin
        pre_next = pre_reg - PDT_PRE_ONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pre_reg <= PDT_PRE_TOP;
    end else begin
      pre_reg <= pre_next;
    end
  end

endmodule : pdt_prescaler
`default_nettype wire

/* File: pdt_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Modes 00X: output and acknowledge pins are plain port lines.
// - Modes 01X: output toggles on zero detect when running, high halted.
// - Mode 100: request pin floats; acknowledge gets no vector, no ack.
// - Mode 101: request low while flag set; acknowledge answered.
// - Mode 110: request pin floats; acknowledge pin is a port line.
// - Mode 111: request low while flag set; acknowledge pin port line.
// - Bit 4 clear: reload from preload on first tick after zero.
// - Bit 4 set: counter wraps to all ones and keeps counting.
// - Control bit 3 has no function and reads as 0.
// - Select 00: prescaler from system clock, counter steps on wrap.
// - Select 01: as 00, but runs only while input pin high.
// - Select 10: prescaler steps on synchronised input rising edges.
// - Select 11: counter steps on synchronised input rising edges.
// - Bit 0 enables the timer; with gating it picks run or halt.
// - Control register always read/write, cleared to zero in reset.
// - Flag sets when the counter steps from one to zero.
// - Writing 1 to status bit 0 clears the flag.
// - Halt clears the flag; clearing beats a simultaneous set.
module pdt_timer
  import pdt_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic [PDT_ADDR_W-1:0] avs_address_i,
  input  wire logic                  avs_read_i,
  input  wire logic                  avs_write_i,
  input  wire logic [PDT_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]            avs_byteenable_i,
  output var  logic [PDT_DATA_W-1:0] avs_readdata_o,
  output var  logic                  avs_waitrequest_o,
  input  wire logic                  dual_pin_c2_i,
  output var  logic                  dual_pin_c2_o,
  output var  logic                  dual_pin_c2_oe_o,
  input  wire logic                  dual_pin_c3_i,
  output var  logic                  dual_pin_c3_o,
  output var  logic                  dual_pin_c3_oe_o,
  input  wire logic                  dual_pin_c7_i,
  output var  logic                  dual_pin_c7_o,
  output var  logic                  dual_pin_c7_oe_o,
  output var  logic                  bus_transfer_ack_o,
  output var  logic [7:0]            int_vector_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pdt_ctrl_type          timer_control_reg;
  pdt_ctrl_type          timer_control_next;
  logic [PDT_CNT_W-1:0]  preload_reg;
  logic [PDT_CNT_W-1:0]  preload_next;
  logic [7:0]            vector_reg;
  logic [7:0]            vector_next;
  logic [7:0]            portc_reg;
  logic [7:0]            portc_next;
  logic [PDT_DATA_W-1:0] rdata_reg;
  logic [PDT_DATA_W-1:0] rdata_next;
  logic                  wait_reg;
  logic                  wait_next;

  logic [PDT_CNT_W-1:0]  count_reg;
  logic [PDT_CNT_W-1:0]  count_next;
  logic                  zero_detect_flag_reg;
  logic                  zero_detect_flag_next;
  logic                  timer_output_pin_level_reg;
  logic                  timer_output_pin_level_next;
  logic                  tin_prev_reg;
  logic                  tin_prev_next;

  pdt_drive_type         c2_reg;
  pdt_drive_type         c2_next;
  pdt_drive_type         c3_reg;
  pdt_drive_type         c3_next;
  pdt_drive_type         c7_reg;
  pdt_drive_type         c7_next;
  logic                  ack_reg;
  logic                  ack_next;
  logic [7:0]            ivec_reg;
  logic [7:0]            ivec_next;

  logic [PDT_SYNC_W-1:0] sync_q;
  logic                  tin_sync;
  logic                  ack_sync;
  logic                  tin_rise;
  logic                  running;
  logic                  pre_step;
  logic                  pre_wrap;
  logic                  tick;
  logic                  zero_event;
  logic                  access;
  logic                  wr_en;
  logic                  status_clear;

  // ----------------------------------------------------------------
  // Pin synchronisers and prescaler
  // ----------------------------------------------------------------
  pdt_sync #(
    .WIDTH   (PDT_SYNC_W),
    .RST_VAL (PDT_SYNC_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     ({dual_pin_c3_i, dual_pin_c7_i, dual_pin_c2_i}),
    .q_o     (sync_q)
  );

  pdt_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .step_i  (pre_step),
    .wrap_o  (pre_wrap)
  );

  // ----------------------------------------------------------------
  // Run state and counting clock
  // ----------------------------------------------------------------
  always_comb begin
    tin_sync = sync_q[PDT_SYNC_TIN];
    ack_sync = sync_q[PDT_SYNC_ACK];
    tin_rise = tin_sync & ~tin_prev_reg;
    running  = timer_control_reg.enable;
    if (timer_control_reg.clk_sel == PDT_CS_GATE) begin
      running = timer_control_reg.enable & tin_sync;
    end
    pre_step = 1'b0;
    tick     = 1'b0;
    if (running) begin
      unique case (timer_control_reg.clk_sel)
        PDT_CS_SYS, PDT_CS_GATE: begin
          pre_step = 1'b1;
          tick     = pre_wrap;
        end
        PDT_CS_EXT_PRE: begin
          pre_step = tin_rise;
          tick     = pre_wrap;
        end
        PDT_CS_EXT: begin
          tick     = tin_rise;
        end
      endcase
    end
    zero_event = tick & (count_reg == PDT_CNT_ONE);
  end

  // ----------------------------------------------------------------
  // Counter, flag and square wave
  // ----------------------------------------------------------------
  always_comb begin
    count_next            = count_reg;
    zero_detect_flag_next = zero_detect_flag_reg;
    timer_output_pin_level_next       = timer_output_pin_level_reg;
    tin_prev_next         = tin_sync;
    if (tick) begin
      if (count_reg == PDT_CNT_ZERO && !timer_control_reg.rollover) begin
        count_next = preload_reg;
      end else begin
        count_next = count_reg - PDT_CNT_ONE;
      end
    end
    if (zero_event) begin
      zero_detect_flag_next = 1'b1;
      timer_output_pin_level_next       = ~timer_output_pin_level_reg;
    end
    if (!running || status_clear) begin
      zero_detect_flag_next = 1'b0;
    end
    if (!running) begin
      timer_output_pin_level_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      count_reg            <= PDT_CNT_ZERO;
      zero_detect_flag_reg <= 1'b0;
      timer_output_pin_level_reg       <= 1'b1;
      tin_prev_reg         <= 1'b0;
    end else begin
      count_reg            <= count_next;
      zero_detect_flag_reg <= zero_detect_flag_next;
      timer_output_pin_level_reg       <= timer_output_pin_level_next;
      tin_prev_reg         <= tin_prev_next;
    end
  end

  // ----------------------------------------------------------------
  // Dual function pins and acknowledge response
  // ----------------------------------------------------------------
  always_comb begin
    c2_next.o  = portc_reg[PDT_PC_C2];
    c2_next.oe = portc_reg[PDT_PC_DIR+PDT_PC_C2];
    c3_next.o  = portc_reg[PDT_PC_C3];
    c3_next.oe = portc_reg[PDT_PC_DIR+PDT_PC_C3];
    c7_next.o  = portc_reg[PDT_PC_C7];
    c7_next.oe = portc_reg[PDT_PC_DIR+PDT_PC_C7];
    ack_next   = 1'b0;
    ivec_next  = 8'h00;
    if (timer_control_reg.clk_sel != PDT_CS_SYS) begin
      c2_next.oe = 1'b0;
    end
    if (timer_control_reg.pin_mode[2:1] == PDT_PIN_SQUARE) begin
      c3_next.o  = timer_output_pin_level_reg;
      c3_next.oe = 1'b1;
    end else if (timer_control_reg.pin_mode[2]) begin
      c3_next.o  = 1'b0;
      c3_next.oe = 1'b0;
      if (timer_control_reg.pin_mode[0]) begin
        c3_next.oe = zero_detect_flag_reg;
      end
      if (!timer_control_reg.pin_mode[1]) begin
        c7_next.oe = 1'b0;
      end
    end
    if (timer_control_reg.pin_mode == PDT_PIN_IRQ_VEC && !ack_sync) begin
      ack_next  = 1'b1;
      ivec_next = vector_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      c2_reg  <= '0;
      c3_reg  <= '0;
      c7_reg  <= '0;
      ack_reg <= 1'b0;
      ivec_reg <= 8'h00;
    end else begin
      c2_reg  <= c2_next;
      c3_reg  <= c3_next;
      c7_reg  <= c7_next;
      ack_reg <= ack_next;
      ivec_reg <= ivec_next;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave, one wait cycle per access
  // ----------------------------------------------------------------
  always_comb begin
    access             = avs_read_i | avs_write_i;
    wr_en              = avs_write_i & ~wait_reg;
    status_clear       = wr_en && avs_address_i == PDT_OFS_STATUS &&
                         avs_byteenable_i[0] &&
                         avs_writedata_i[PDT_ST_FLAG];
    wait_next          = ~(access & wait_reg);
    rdata_next         = rdata_reg;
    timer_control_next = timer_control_reg;
    preload_next       = preload_reg;
    vector_next        = vector_reg;
    portc_next         = portc_reg;
    if (access && wait_reg) begin
      rdata_next = '0;
      unique case (avs_address_i)
        PDT_OFS_CTRL: begin
          rdata_next[7:0] = timer_control_reg;
          rdata_next[3]   = 1'b0;
        end
        PDT_OFS_STATUS:  rdata_next[PDT_ST_FLAG] = zero_detect_flag_reg;
        PDT_OFS_PRELOAD: rdata_next[PDT_CNT_W-1:0] = preload_reg;
        PDT_OFS_COUNT:   rdata_next[PDT_CNT_W-1:0] = count_reg;
        PDT_OFS_VECTOR:  rdata_next[7:0] = vector_reg;
        PDT_OFS_PORTC: begin
          rdata_next[7:0]              = portc_reg;
          rdata_next[PDT_PC_PIN+PDT_PC_C2] = tin_sync;
          rdata_next[PDT_PC_PIN+PDT_PC_C3] = c3_reg.oe ? c3_reg.o
                                                        : sync_q[PDT_SYNC_C3];
          rdata_next[PDT_PC_PIN+PDT_PC_C7] = ack_sync;
        end
        default: rdata_next = '0;
      endcase
    end
    if (wr_en && avs_byteenable_i[0]) begin
      unique case (avs_address_i)
        PDT_OFS_CTRL: begin
          timer_control_next        = avs_writedata_i[7:0];
          timer_control_next.unused = 1'b0;
        end
        PDT_OFS_VECTOR: vector_next = avs_writedata_i[7:0];
        PDT_OFS_PORTC:  portc_next  = avs_writedata_i[7:0];
        default: ;
      endcase
    end
    if (wr_en && avs_address_i == PDT_OFS_PRELOAD) begin
      for (int b = 0; b < 3; b++) begin
        if (avs_byteenable_i[b]) begin
          preload_next[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      timer_control_reg <= PDT_CTRL_RST;
      preload_reg       <= PDT_CNT_ZERO;
      vector_reg        <= PDT_VECTOR_RST;
      portc_reg         <= PDT_PORTC_RST;
      rdata_reg         <= '0;
      wait_reg          <= 1'b1;
    end else begin
      timer_control_reg <= timer_control_next;
      preload_reg       <= preload_next;
      vector_reg        <= vector_next;
      portc_reg         <= portc_next;
      rdata_reg         <= rdata_next;
      wait_reg          <= wait_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    avs_readdata_o     = rdata_reg;
    avs_waitrequest_o  = wait_reg;
    dual_pin_c2_o      = c2_reg.o;
    dual_pin_c2_oe_o   = c2_reg.oe;
    dual_pin_c3_o      = c3_reg.o;
    dual_pin_c3_oe_o   = c3_reg.oe;
    dual_pin_c7_o      = c7_reg.o;
    dual_pin_c7_oe_o   = c7_reg.oe;
    bus_transfer_ack_o = ack_reg;
    int_vector_o       = ivec_reg;
  end

endmodule : pdt_timer
`default_nettype wire

/* File: pdt_timer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_monitor
  import pdt_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_b_i,
  input wire logic [PDT_ADDR_W-1:0] avs_address_i,
  input wire logic                  avs_read_i,
  input wire logic                  avs_write_i,
  input wire logic [PDT_DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0]            avs_byteenable_i,
  input wire logic                  avs_waitrequest_o,
  input wire logic                  dual_pin_c2_oe_o,
  input wire logic                  dual_pin_c3_o,
  input wire logic                  dual_pin_c3_oe_o,
  input wire logic                  dual_pin_c7_i,
  input wire logic                  dual_pin_c7_oe_o,
  input wire logic                  bus_transfer_ack_o,
  input wire logic [7:0]            int_vector_o
);
  // ------
  // Control shadow
  // ------
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [7:0] old_reg;
  logic [7:0] old_next;
  logic       stab;

  assign stab = (ctl_reg == old_reg);

  always_comb begin
    ctl_next = ctl_reg;
    old_next = ctl_reg;
    if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
        && avs_address_i == PDT_OFS_CTRL) begin
      ctl_next = avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctl_reg <= PDT_CTRL_RST;
      old_reg <= PDT_CTRL_RST;
    end else begin
      ctl_reg <= ctl_next;
      old_reg <= old_next;
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer late");
  property p_rst;
    disable iff (1'b0) !rst_b_i |=> avs_waitrequest_o && !bus_transfer_ack_o
      && !dual_pin_c3_oe_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared in reset");
  property p_irq_od;
    stab && ctl_reg[7] && dual_pin_c3_oe_o |-> !dual_pin_c3_o;
  endproperty
  a_irq_od: assert property (p_irq_od)
    else $error("request pin driven high");
  property p_irq_off;
    stab && ctl_reg[7] && !ctl_reg[5] |-> !dual_pin_c3_oe_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("disabled request pin driven");
  property p_no_ack;
    stab && ctl_reg[7:5] != PDT_PIN_IRQ_VEC |-> !bus_transfer_ack_o
      && int_vector_o == 8'h00;
  endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("acknowledge answered outside vectored mode");
  property p_ack;
    (stab && ctl_reg[7:5] == PDT_PIN_IRQ_VEC && !dual_pin_c7_i)[*5]
      |-> bus_transfer_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge not answered");
  property p_c7_in;
    stab && ctl_reg[7:6] == 2'b10 |-> !dual_pin_c7_oe_o;
  endproperty
  a_c7_in: assert property (p_c7_in)
    else $error("acknowledge pin driven");
  property p_sq_halt;
    (stab && ctl_reg[7:6] == 2'b01 && !ctl_reg[0])[*3]
      |-> dual_pin_c3_o && dual_pin_c3_oe_o;
  endproperty
  a_sq_halt: assert property (p_sq_halt)
    else $error("square output not high while halted");
  property p_c2_in;
    (ctl_reg[2:1] != PDT_CS_SYS)[*2] |-> !dual_pin_c2_oe_o;
  endproperty
  a_c2_in: assert property (p_c2_in)
    else $error("timer input pin driven");

  c_ack: cover property (bus_transfer_ack_o);
  c_irq: cover property (ctl_reg[7] && dual_pin_c3_oe_o);
  c_sq: cover property (ctl_reg[7:6] == 2'b01 && !dual_pin_c3_o);
endmodule : pdt_timer_monitor
`default_nettype wire

/* File: pdt_pin_env.sv */
`timescale 1ns/1ps
`default_nettype none
module pdt_pin_env
  import pdt_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic c2_o_i,
  input  wire logic c2_oe_i,
  input  wire logic c3_o_i,
  input  wire logic c3_oe_i,
  input  wire logic c7_o_i,
  input  wire logic c7_oe_i,
  output var  logic c2_pin_o,
  output var  logic c3_pin_o,
  output var  logic c7_pin_o
);
  logic tin_reg   = 1'b0;
  logic ack_b_reg = 1'b1;

  // ------
  // Pin levels; c3 pulled up when released, c2 and c7 then take the driven levels
  // ------
  assign c2_pin_o = c2_oe_i ? c2_o_i : tin_reg;
  assign c3_pin_o = c3_oe_i ? c3_o_i : 1'b1;
  assign c7_pin_o = c7_oe_i ? c7_o_i : ack_b_reg;

  task automatic drive(input logic timer_input_pin, input logic ack_b);
    tin_reg   <= timer_input_pin;
    ack_b_reg <= ack_b;
  endtask : drive

  task automatic pulses(input int n);
    repeat (n) begin
      tin_reg <= 1'b1;
      repeat (3) @(posedge clk_i);
      tin_reg <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : pulses
endmodule : pdt_pin_env
`default_nettype wire

/* File: pdt_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_tb
  import pdt_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wait_o, c2_i, c2_o, c2_oe, c3_i, c3_o, c3_oe;
  logic        c7_i, c7_o, c7_oe, ack;
  logic [7:0]  vec;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic [31:0] rng = 32'h1F97D04D;
  logic [32:0] exp_q[$];
  logic [32:0] note;

  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;

  pdt_timer i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr_en), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
    .dual_pin_c2_i(c2_i), .dual_pin_c2_o(c2_o), .dual_pin_c2_oe_o(c2_oe),
    .dual_pin_c3_i(c3_i), .dual_pin_c3_o(c3_o), .dual_pin_c3_oe_o(c3_oe),
    .dual_pin_c7_i(c7_i), .dual_pin_c7_o(c7_o), .dual_pin_c7_oe_o(c7_oe),
    .bus_transfer_ack_o(ack), .int_vector_o(vec));

  pdt_pin_env i_env (.clk_i(clk_i), .c2_o_i(c2_o), .c2_oe_i(c2_oe),
    .c3_o_i(c3_o), .c3_oe_i(c3_oe), .c7_o_i(c7_o), .c7_oe_i(c7_oe),
    .c2_pin_o(c2_i), .c3_pin_o(c3_i), .c7_pin_o(c7_i));

  // ------
  // Bus and compare tasks
  // ------
  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xorshift

  task automatic chk_word(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk_word

  task automatic chk_pin(input string s, input logic e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %b seen %b", s, e, g);
    end
  endtask : chk_pin

  task automatic bus(input logic r, input logic [7:0] a,
                     input logic [31:0] d, input logic ck,
                     output logic [31:0] q);
    if (r) exp_q.push_back({ck, d});
    adr   <= a;
    wdat  <= r ? 32'h0 : d;
    rd    <= r;
    wr_en <= !r;
    do begin
      @(posedge clk_i);
    end while (wait_o !== 1'b0);
    q = rdat;
    rd    <= 1'b0;
    wr_en <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, 1'b0, q);
  endtask : wr

  task automatic ck_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, e, 1'b1, q);
  endtask : ck_rd

  task automatic wait_flag(output int t);
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h0;
    while (q[0] !== 1'b1 && n < 60) begin
      bus(1'b1, PDT_OFS_STATUS, 32'h0, 1'b0, q);
      n++;
    end
    t = cyc;
    chk_pin("flag", 1'b1, q[0]);
  endtask : wait_flag

  task automatic do_reset();
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
  endtask : do_reset

  task automatic mode_case(input logic [2:0] m);
    int t;
    do_reset();
    i_env.drive(1'b0, 1'b0);
    wr(PDT_OFS_PORTC, 32'h77);
    wr(PDT_OFS_PRELOAD, 32'h1);
    wr(PDT_OFS_CTRL, {24'h0, m, 5'h01});
    wait_flag(t);
    chk_pin("c3_oe", m != 4 && m != 6, c3_oe);
    chk_pin("c3_o", m < 2, c3_o);
    chk_pin("c7_oe", m != 4 && m != 5, c7_oe);
    chk_pin("ack", m == 5, ack);
    chk_word("vector", (m == 5) ? 32'hF : 32'h0, {24'h0, vec});
    chk_word("c2_c7", 32'h7, {29'h0, c2_o, c2_oe, c7_o});
    wr(PDT_OFS_STATUS, 32'h1);
    ck_rd(PDT_OFS_STATUS, 32'h0);
    chk_pin("c3_oe", m < 4, c3_oe);
    wr(PDT_OFS_CTRL, {24'h0, m, 5'h00});
    repeat (3) @(posedge clk_i);
    chk_pin("c3_o", m < 4, c3_o);
  endtask : mode_case

  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // ------
  // Checking and stimulus
  // ------
  always @(posedge clk_i) begin
    if (rd && wait_o === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[32]) chk_word("readdata", note[31:0], rdat);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    summarize();
  end

  initial begin
    logic [31:0] v;
    int t0;
    int t1;
    do_reset();
    ck_rd(PDT_OFS_CTRL, 32'h0);
    ck_rd(8'h18, 32'h0);
    for (int i = 0; i < 6; i++) begin
      v = xorshift() | 32'h8;
      v[0] = 1'b0;
      wr(PDT_OFS_CTRL, v);
      ck_rd(PDT_OFS_CTRL, {24'h0, v[7:0] & 8'hF7});
    end
    for (int m = 0; m < 8; m++) mode_case(m[2:0]);
    do_reset();
    wr(PDT_OFS_PRELOAD, 32'h3);
    wr(PDT_OFS_CTRL, 32'h01);
    wait_flag(t0);
    ck_rd(PDT_OFS_COUNT, 32'h0);
    repeat (32) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, 32'h3);
    wr(PDT_OFS_STATUS, 32'h1);
    wait_flag(t1);
    chk_pin("period", 1'b1, (t1 - t0) inside {[125:131]});
    wr(PDT_OFS_CTRL, 32'h00);
    ck_rd(PDT_OFS_STATUS, 32'h0);
    bus(1'b1, PDT_OFS_COUNT, 32'h0, 1'b0, v);
    repeat (70) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, v);
    do_reset();
    wr(PDT_OFS_PRELOAD, 32'h5);
    wr(PDT_OFS_CTRL, 32'h11);
    repeat (40) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, 32'hFFFFFF);
    do_reset();
    i_env.drive(1'b0, 1'b1);
    wr(PDT_OFS_PRELOAD, 32'h3);
    wr(PDT_OFS_CTRL, 32'h03);
    repeat (80) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, 32'h0);
    i_env.drive(1'b1, 1'b1);
    repeat (40) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, 32'h3);
    i_env.drive(1'b0, 1'b1);
    do_reset();
    wr(PDT_OFS_PRELOAD, 32'h9);
    wr(PDT_OFS_CTRL, 32'h05);
    i_env.pulses(31);
    repeat (6) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, 32'h0);
    i_env.pulses(1);
    repeat (6) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, 32'h9);
    do_reset();
    wr(PDT_OFS_PRELOAD, 32'h9);
    wr(PDT_OFS_CTRL, 32'h07);
    i_env.pulses(4);
    repeat (6) @(posedge clk_i);
    ck_rd(PDT_OFS_COUNT, 32'h6);
    summarize();
  end
endmodule : pdt_timer_tb

bind pdt_timer pdt_timer_monitor i_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
  .dual_pin_c2_oe_o(dual_pin_c2_oe_o), .dual_pin_c3_o(dual_pin_c3_o),
  .dual_pin_c3_oe_o(dual_pin_c3_oe_o), .dual_pin_c7_i(dual_pin_c7_i),
  .dual_pin_c7_oe_o(dual_pin_c7_oe_o), .bus_transfer_ack_o(bus_transfer_ack_o),
  .int_vector_o(int_vector_o));
`default_nettype wire
